// file: src/dmd_pkg.sv
// Purpose: shared constants and types for the multiply datapath
// Assumes: 16-bit core data, 40-bit accumulator path
// Notes: op codes are sampled on the request strobe
package dmd_pkg;
   localparam int OPND_W = 16;
   localparam int MULT_W = 17;
   localparam int PROD_W = 33;
   localparam int ACC_W = 40;
   localparam int GUARD_LSB = 32;
   localparam int SHIFT_MAX = 16;
   localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
   localparam logic [31:0] RES_RST = 32'h0000_0000;
   localparam logic [39:0] SAT_POS = 40'h7f_ffff_ffff;
   localparam logic [39:0] SAT_NEG = 40'h80_0000_0000;

   // operand sign modes: bit1 = operand a signed, bit0 = operand b signed
   typedef enum logic [1:0] {
      DMD_UU = 2'b00,
      DMD_US = 2'b01,
      DMD_SU = 2'b10,
      DMD_SS = 2'b11
   } dmd_sign_t;

   typedef enum logic [2:0] {
      DMD_OP_MUL = 3'b001,
      DMD_OP_MAC = 3'b010,
      DMD_OP_SHF = 3'b100
   } dmd_op_t;
endpackage

// file: src/dmd_datapath.sv
// Purpose: fixed-point multiply, scale, shift and accumulate datapath of the core
// Assumes: operands come from the working registers, one op per cycle on op_valid
// Notes: results register one cycle after the request; no trap or saturation flags kept
`timescale 1ns/1ps
module dmd_datapath #(
   parameter int SHIFT_LIMIT = dmd_pkg::SHIFT_MAX
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire dmd_pkg::dmd_op_t op_sel,
   input wire dmd_pkg::dmd_sign_t sign_mode,
   input wire logic frac_mode,
   input wire logic byte_mode,
   input wire logic acc_sel_b,
   input wire logic sat_en_a,
   input wire logic sat_en_b,
   input wire logic [15:0] opnd_a,
   input wire logic [15:0] opnd_b,
   input wire logic [39:0] shift_in,
   input wire logic shift_left,
   input wire logic [4:0] shift_amt,
   output logic [31:0] mul_result,
   output logic mul_done,
   output logic [39:0] product_ext,
   output logic [39:0] shift_out,
   output logic [39:0] accumulator_a,
   output logic [39:0] accumulator_b,
   output logic acc_a_guard_overflow_flag,
   output logic acc_b_guard_overflow_flag
);
   logic [16:0] mul_a;
   logic [16:0] mul_b;
   logic signed [33:0] raw_prod;
   logic [32:0] scaled;
   logic [39:0] prod40;
   logic [39:0] acc_src;
   logic [39:0] acc_sum;
   logic [39:0] acc_new;
   logic [39:0] shift_next;
   logic [4:0] amt;
   logic acc_sat_en;
   logic [7:0] a_byte;
   logic [7:0] b_byte;
   logic [15:0] ext_a;
   logic [15:0] ext_b;
   logic load_a;
   logic load_b;

   // byte mode narrows the operands before extension
   always_comb begin
      a_byte = opnd_a[7:0];
      b_byte = opnd_b[7:0];
      if (byte_mode) begin
         ext_a = sign_mode[1] ? {{8{a_byte[7]}}, a_byte} : {8'h00, a_byte};
         ext_b = sign_mode[0] ? {{8{b_byte[7]}}, b_byte} : {8'h00, b_byte};
      end else begin
         ext_a = opnd_a;
         ext_b = opnd_b;
      end
   end

   // 17th bit: sign copy or zero, chosen per operand
   assign mul_a = {sign_mode[1] & ext_a[15], ext_a};
   assign mul_b = {sign_mode[0] & ext_b[15], ext_b};

   // both inputs are true 17-bit two's complement after extension
   assign raw_prod = $signed(mul_a) * $signed(mul_b);

   // fractional keeps one sign bit by shifting out the duplicate
   always_comb begin
      if (frac_mode) begin
         scaled = {raw_prod[31:0], 1'b0};
      end else begin
         scaled = raw_prod[32:0];
      end
   end

   assign prod40 = {{7{scaled[32]}}, scaled};

   always_comb begin
      amt = (shift_amt > 5'(SHIFT_LIMIT)) ? 5'(SHIFT_LIMIT) : shift_amt;
      if (shift_left) begin
         shift_next = shift_in << amt;
      end else begin
         shift_next = $unsigned($signed(shift_in) >>> amt);
      end
   end

   // adder reads and writes the same selected accumulator
   assign acc_src = acc_sel_b ? accumulator_b : accumulator_a;
   assign acc_sum = acc_src + prod40;
   assign acc_sat_en = acc_sel_b ? sat_en_b : sat_en_a;

   // 40-bit saturation on signed overflow out of bit 39; 31-bit mode not modelled
   always_comb begin
      acc_new = acc_sum;
      if (acc_sat_en && (acc_src[39] == prod40[39]) && (acc_sum[39] != acc_src[39])) begin
         acc_new = acc_src[39] ? dmd_pkg::SAT_NEG : dmd_pkg::SAT_POS;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mul_result <= dmd_pkg::RES_RST;
         product_ext <= dmd_pkg::ACC_RST;
         mul_done <= 1'b0;
      end else begin
         mul_done <= op_valid && (op_sel == dmd_pkg::DMD_OP_MUL);
         if (op_valid && (op_sel != dmd_pkg::DMD_OP_SHF)) begin
            product_ext <= prod40;
         end
         if (op_valid && (op_sel == dmd_pkg::DMD_OP_MUL)) begin
            mul_result <= byte_mode ? {16'h0000, scaled[15:0]} : scaled[31:0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shift_out <= dmd_pkg::ACC_RST;
      end else if (op_valid && (op_sel == dmd_pkg::DMD_OP_SHF)) begin
         shift_out <= shift_next;
      end
   end

   // each accumulator is its own slot, so the unselected one cannot be disturbed
   assign load_a = op_valid && (op_sel == dmd_pkg::DMD_OP_MAC) && !acc_sel_b;
   assign load_b = op_valid && (op_sel == dmd_pkg::DMD_OP_MAC) && acc_sel_b;

   dmd_acc_slot #(
      .WIDTH(dmd_pkg::ACC_W),
      .GUARD_LO(dmd_pkg::GUARD_LSB)
   ) u_acc_a (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(load_a),
      .acc_next(acc_new),
      .acc_reg(accumulator_a),
      .guard_ovf_reg(acc_a_guard_overflow_flag)
   );

   dmd_acc_slot #(
      .WIDTH(dmd_pkg::ACC_W),
      .GUARD_LO(dmd_pkg::GUARD_LSB)
   ) u_acc_b (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(load_b),
      .acc_next(acc_new),
      .acc_reg(accumulator_b),
      .guard_ovf_reg(acc_b_guard_overflow_flag)
   );

   chk_mul_done_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MUL |=> mul_done)
      else $error("multiply done missing");
   chk_word_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MUL && !byte_mode && !frac_mode
      |=> mul_result == $past(raw_prod[31:0]))
      else $error("word product wrong");
   chk_byte_upper_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MUL && byte_mode |=> mul_result[31:16] == 16'h0000)
      else $error("byte result upper half not zero");
   chk_sign_extend: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel != dmd_pkg::DMD_OP_SHF
      |=> (&product_ext[39:32]) || !(|product_ext[39:32]))
      else $error("product not sign extended");
   chk_frac_lsb: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel != dmd_pkg::DMD_OP_SHF && frac_mode |=> product_ext[0] == 1'b0)
      else $error("fractional product not shifted");
   chk_unsigned_pos: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && sign_mode == dmd_pkg::DMD_UU
      |=> !product_ext[39])
      else $error("unsigned product negative");
   chk_acc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && acc_sel_b |=> $stable(accumulator_a))
      else $error("unselected accumulator changed");
   chk_shift_left: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_SHF && shift_left && shift_amt == 5'h01
      |=> shift_out == {$past(shift_in[38:0]), 1'b0})
      else $error("left shift by one wrong");
   chk_guard_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && !acc_sel_b
      |=> acc_a_guard_overflow_flag == !((&accumulator_a[39:32]) || !(|accumulator_a[39:32])))
      else $error("guard flag mismatch");
   chk_guard_flag_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && acc_sel_b
      |=> acc_b_guard_overflow_flag == !((&accumulator_b[39:32]) || !(|accumulator_b[39:32])))
      else $error("guard flag b mismatch");
   chk_acc_hold_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && !acc_sel_b |=> $stable(accumulator_b))
      else $error("unselected accumulator b changed");
   chk_mac_sum_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && !acc_sel_b && !sat_en_a
      |=> accumulator_a == $past(accumulator_a) + product_ext)
      else $error("accumulate a sum wrong");
   chk_mac_sum_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && acc_sel_b && !sat_en_b
      |=> accumulator_b == $past(accumulator_b) + product_ext)
      else $error("accumulate b sum wrong");
   chk_sat_pos_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && !acc_sel_b && sat_en_a
      && !accumulator_a[39] && !prod40[39] |=> !accumulator_a[39])
      else $error("saturating accumulator a wrapped negative");
   chk_sat_pos_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MAC && acc_sel_b && sat_en_b
      && !accumulator_b[39] && !prod40[39] |=> !accumulator_b[39])
      else $error("saturating accumulator b wrapped negative");
   chk_shift_clamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_SHF && shift_left && shift_amt > 5'h10
      |=> shift_out == {$past(shift_in[23:0]), 16'h0000})
      else $error("oversized shift not clamped");
   chk_shift_right: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_SHF && !shift_left && shift_amt == 5'h01
      |=> shift_out == {$past(shift_in[39]), $past(shift_in[39:1])})
      else $error("right shift by one wrong");
   chk_mul_done_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !(op_valid && op_sel == dmd_pkg::DMD_OP_MUL) |=> !mul_done)
      else $error("multiply done without request");
   chk_result_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !(op_valid && op_sel == dmd_pkg::DMD_OP_MUL) |=> $stable(mul_result))
      else $error("multiply result changed without request");
   chk_shift_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !(op_valid && op_sel == dmd_pkg::DMD_OP_SHF) |=> $stable(shift_out))
      else $error("shift output changed without request");
   chk_prod_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !(op_valid && op_sel != dmd_pkg::DMD_OP_SHF) |=> $stable(product_ext))
      else $error("product changed without request");
   chk_signed_ext: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sign_mode == dmd_pkg::DMD_SS |-> mul_a[16] == ext_a[15] && mul_b[16] == ext_b[15])
      else $error("signed operand not sign extended");
   chk_mixed_ext: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sign_mode == dmd_pkg::DMD_SU |-> mul_a[16] == ext_a[15] && !mul_b[16])
      else $error("mixed operand extension wrong");
   chk_unsigned_ext: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sign_mode == dmd_pkg::DMD_UU |-> !mul_a[16] && !mul_b[16])
      else $error("unsigned operand not zero extended");
   chk_byte_unsigned: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_valid && op_sel == dmd_pkg::DMD_OP_MUL && byte_mode && !frac_mode
      && sign_mode == dmd_pkg::DMD_UU
      |=> mul_result == $past(opnd_a[7:0]) * $past(opnd_b[7:0]))
      else $error("unsigned byte product wrong");
endmodule // dmd_datapath

// one accumulator with its guard overflow flag
module dmd_acc_slot #(
   parameter int WIDTH = dmd_pkg::ACC_W,
   parameter int GUARD_LO = dmd_pkg::GUARD_LSB
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] acc_next,
   output logic [WIDTH-1:0] acc_reg,
   output logic guard_ovf_reg
);
   logic guard_ovf_next;

   // flag follows every adder pass into this slot, so a later clean sum clears it
   assign guard_ovf_next = !((&acc_next[WIDTH-1:GUARD_LO])
      || !(|acc_next[WIDTH-1:GUARD_LO]));

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         acc_reg <= WIDTH'(dmd_pkg::ACC_RST);
      end else if (load) begin
         acc_reg <= acc_next;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         guard_ovf_reg <= 1'b0;
      end else if (load) begin
         guard_ovf_reg <= guard_ovf_next;
      end
   end

   chk_slot_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !load |=> $stable(acc_reg) && $stable(guard_ovf_reg))
      else $error("accumulator slot changed without load");
   chk_slot_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      load |=> acc_reg == $past(acc_next))
      else $error("accumulator slot missed its load");
   chk_slot_guard: assert property (@(posedge clk_sys) disable iff (sys_rst)
      load && (acc_next[WIDTH-1:GUARD_LO] == '0) |=> !guard_ovf_reg)
      else $error("guard flag set on clean sum");
endmodule // dmd_acc_slot

// file: testbench/dmd_issue_model.sv
// Purpose: stand-in for instruction decode and the working register file
// Assumes: fields change only at the falling edge
// Notes: one request per call; op_valid drops a cycle later so no edge sees a stale op
`timescale 1ns/1ps
module dmd_issue_model (
   input wire logic clk_sys,
   output logic op_valid,
   output dmd_pkg::dmd_op_t op_sel,
   output dmd_pkg::dmd_sign_t sign_mode,
   output logic frac_mode,
   output logic byte_mode,
   output logic acc_sel_b,
   output logic [15:0] opnd_a,
   output logic [15:0] opnd_b
);
   initial begin
      op_valid = 1'b0;
      {frac_mode, byte_mode, acc_sel_b, opnd_a, opnd_b} = 35'h0;
      op_sel = dmd_pkg::DMD_OP_MUL;
      sign_mode = dmd_pkg::DMD_SS;
   end

   task automatic issue(input dmd_pkg::dmd_op_t op, input dmd_pkg::dmd_sign_t sm,
                        input logic [2:0] fba, input logic [15:0] a, input logic [15:0] b);
      @(negedge clk_sys);
      op_sel = op;
      sign_mode = sm;
      {frac_mode, byte_mode, acc_sel_b} = fba;
      opnd_a = a;
      opnd_b = b;
      op_valid = 1'b1;
      @(negedge clk_sys);
      op_valid = 1'b0;
   endtask
endmodule // dmd_issue_model

// file: testbench/tb_dsp_multiplier_datapath.sv
// Purpose: self-checking bench for the multiply datapath
// Assumes: results are read at the falling edge after the request
// Notes: saturation is driven only towards the positive limit
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t mismatch", $time); end end
module tb_dsp_multiplier_datapath;
   localparam dmd_pkg::dmd_op_t MUL = dmd_pkg::DMD_OP_MUL;
   localparam dmd_pkg::dmd_op_t MAC = dmd_pkg::DMD_OP_MAC;
   localparam dmd_pkg::dmd_sign_t SS = dmd_pkg::DMD_SS;
   localparam dmd_pkg::dmd_sign_t UU = dmd_pkg::DMD_UU;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [39:0] shift_in = 40'h0;
   logic shift_left = 1'b0;
   logic [4:0] shift_amt = 5'h0;
   logic sat_en_a = 1'b0;
   logic sat_en_b = 1'b0;
   logic op_valid, frac_mode, byte_mode, acc_sel_b, mul_done, ov_a, ov_b;
   dmd_pkg::dmd_op_t op_sel;
   dmd_pkg::dmd_sign_t sign_mode;
   logic [15:0] opnd_a, opnd_b;
   logic [31:0] mul_result;
   logic [39:0] product_ext, shift_out, acc_a, acc_b;
   int failures = 0;
   int tests_run = 0;

   initial forever #50 clk_sys = ~clk_sys;

   dmd_issue_model ism (.clk_sys(clk_sys), .op_valid(op_valid), .op_sel(op_sel),
      .sign_mode(sign_mode), .frac_mode(frac_mode), .byte_mode(byte_mode),
      .acc_sel_b(acc_sel_b), .opnd_a(opnd_a), .opnd_b(opnd_b));
   dmd_datapath DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .op_valid(op_valid),
      .op_sel(op_sel), .sign_mode(sign_mode), .frac_mode(frac_mode),
      .byte_mode(byte_mode), .acc_sel_b(acc_sel_b), .sat_en_a(sat_en_a), .sat_en_b(sat_en_b),
      .opnd_a(opnd_a), .opnd_b(opnd_b), .shift_in(shift_in), .shift_left(shift_left),
      .shift_amt(shift_amt), .mul_result(mul_result), .mul_done(mul_done),
      .product_ext(product_ext), .shift_out(shift_out), .accumulator_a(acc_a),
      .accumulator_b(acc_b), .acc_a_guard_overflow_flag(ov_a),
      .acc_b_guard_overflow_flag(ov_b));

   task automatic t_int();
      ism.issue(MUL, SS, 3'h0, 16'hfffd, 16'h0005);
      `CHK(mul_result, 32'hffff_fff1)
      `CHK(product_ext, 40'hff_ffff_fff1)
      `CHK(mul_done, 1'b1)
      ism.issue(MUL, UU, 3'h0, 16'hffff, 16'hffff);
      `CHK(mul_result, 32'hfffe_0001)
      `CHK(product_ext, 40'h00_fffe_0001)
      ism.issue(MUL, dmd_pkg::DMD_SU, 3'h0, 16'hffff, 16'h0002);
      `CHK(mul_result, 32'hffff_fffe)
      ism.issue(MUL, dmd_pkg::DMD_US, 3'h0, 16'h0002, 16'hffff);
      `CHK(mul_result, 32'hffff_fffe)
      @(negedge clk_sys);
      `CHK(mul_done, 1'b0)
      $display("integer multiply done");
   endtask

   task automatic t_frac_byte();
      ism.issue(MUL, SS, 3'h4, 16'h4000, 16'h4000);
      `CHK(product_ext, 40'h00_2000_0000)
      ism.issue(MUL, SS, 3'h4, 16'h8000, 16'h4000);
      `CHK(product_ext, 40'hff_c000_0000)
      ism.issue(MUL, SS, 3'h2, 16'h12fe, 16'h3403);
      `CHK(mul_result, 32'h0000_fffa)
      ism.issue(MUL, UU, 3'h2, 16'h12fe, 16'h3403);
      `CHK(mul_result, 32'h0000_02fa)
      $display("fraction and byte done");
   endtask

   task automatic t_mac();
      ism.issue(MAC, SS, 3'h0, 16'h8000, 16'h8000);
      `CHK(acc_a, 40'h00_4000_0000)
      `CHK(ov_a, 1'b0)
      ism.issue(MAC, SS, 3'h0, 16'h8000, 16'h8000);
      `CHK(acc_a, 40'h00_8000_0000)
      `CHK(ov_a, 1'b0)
      ism.issue(MAC, SS, 3'h4, 16'h8000, 16'h8000);
      `CHK(acc_a, 40'h01_0000_0000)
      `CHK(ov_a, 1'b1)
      ism.issue(MAC, SS, 3'h1, 16'hfffd, 16'h0005);
      `CHK(acc_b, 40'hff_ffff_fff1)
      `CHK(acc_a, 40'h01_0000_0000)
      `CHK(ov_b, 1'b0)
      ism.issue(MAC, UU, 3'h1, 16'hffff, 16'hffff);
      `CHK(acc_b, 40'h00_fffd_fff2)
      {sat_en_a, sat_en_b} = 2'b11;
      repeat (256) begin
         ism.issue(MAC, SS, 3'h4, 16'h8000, 16'h8000);
         ism.issue(MAC, SS, 3'h5, 16'h8000, 16'h8000);
      end
      `CHK(acc_a, 40'h7f_ffff_ffff)
      `CHK(acc_b, 40'h7f_ffff_ffff)
      `CHK(ov_b, 1'b1)
      $display("accumulate done");
   endtask

   task automatic t_shift();
      {shift_in, shift_left, shift_amt} = {40'h00_0000_1234, 1'b1, 5'h10};
      ism.issue(dmd_pkg::DMD_OP_SHF, SS, 3'h0, 16'h0, 16'h0);
      `CHK(shift_out, 40'h00_1234_0000)
      {shift_in, shift_left, shift_amt} = {40'h80_0000_0000, 1'b0, 5'h04};
      ism.issue(dmd_pkg::DMD_OP_SHF, SS, 3'h0, 16'h0, 16'h0);
      `CHK(shift_out, 40'hf8_0000_0000)
      {shift_in, shift_left, shift_amt} = {40'h80_0000_ffff, 1'b1, 5'h1f};
      ism.issue(dmd_pkg::DMD_OP_SHF, SS, 3'h0, 16'h0, 16'h0);
      `CHK(shift_out, 40'h00_ffff_0000)
      {shift_in, shift_left, shift_amt} = {40'h80_0000_0003, 1'b0, 5'h01};
      ism.issue(dmd_pkg::DMD_OP_SHF, SS, 3'h0, 16'h0, 16'h0);
      `CHK(shift_out, 40'hc0_0000_0001)
      {shift_in, shift_left, shift_amt} = {40'h40_0000_0001, 1'b1, 5'h01};
      ism.issue(dmd_pkg::DMD_OP_SHF, SS, 3'h0, 16'h0, 16'h0);
      `CHK(shift_out, 40'h80_0000_0002)
      $display("shift done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      t_int();
      t_frac_byte();
      t_mac();
      t_shift();
      summarize();
   end

   // about eleven hundred cycles of work, so three hundred microseconds means a hang
   initial begin
      #300000;
      failures++;
      summarize();
   end
endmodule // tb_dsp_multiplier_datapath
